// File: hw/lbs_top.sv
// Display supply, sleep and memory control with AXI4-Lite registers
//
// The AXI4-Lite register port was decided locally.
`include "lbs_defines.svh"
module lbs_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Power state
  input wire logic deep_sleep_state,
  // Display scanner
  input wire logic [3:0] view_addr,
  output logic [7:0] view_data,
  // Supply and pin control
  output logic pump_enable,
  output logic ladder_source_select,
  output logic [5:0] contrast_level,
  output logic display_active,
  output lbs_pkg::lbs_seg_t segment_enable,
  output logic [3:0] common_enable,
  output logic reference_keepalive
);
  import lbs_pkg::*;

  lbs_state_t s;
  lbs_state_t n;
  logic wr_fire;
  logic [5:0] wr_maddr;
  lbs_mem_if #(.AW(6)) mif ();

  ////////////////////////////////////////////////////////////////
  // Address decode shared by reads and writes
  function automatic logic lbs_known(input logic [9:0] idx);
    case (idx)
      `LBS_IDX_MAIN, `LBS_IDX_SEG_A, `LBS_IDX_SUPPLY, `LBS_IDX_PTR,
      `LBS_IDX_DATA, `LBS_IDX_UPDATE, `LBS_IDX_SEG_B, `LBS_IDX_PERIPHERAL_CONFIG: lbs_known = 1'b1;
      default: lbs_known = 1'b0;
    endcase
  endfunction

  // Register read mux
  function automatic logic [7:0] lbs_read(input lbs_state_t st, input logic [9:0] idx);
    case (idx)
      `LBS_IDX_MAIN: lbs_read = st.main_cfg;
      `LBS_IDX_SEG_A: lbs_read = st.seg_a;
      `LBS_IDX_SUPPLY: lbs_read = st.supply;
      `LBS_IDX_PTR: lbs_read = st.ptr;
      `LBS_IDX_DATA: lbs_read = st.data;
      `LBS_IDX_UPDATE: lbs_read = st.update;
      `LBS_IDX_SEG_B: lbs_read = st.seg_b;
      `LBS_IDX_PERIPHERAL_CONFIG: lbs_read = st.peripheral_config;
      default: lbs_read = 8'h00;
    endcase
  endfunction

  // Commons driven for each multiplex mode
  function automatic logic [3:0] lbs_coms(input lbs_mux_t mux);
    case (mux)
      MUX_2X: lbs_coms = 4'h3;
      MUX_3X: lbs_coms = 4'h7;
      MUX_4X: lbs_coms = 4'hf;
      default: lbs_coms = 4'h1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  // Handshake outputs
  assign awready = !s.aw_ok && !s.bvalid;
  assign wready = !s.w_ok && !s.bvalid;
  assign arready = !s.rvalid;
  assign wr_fire = s.aw_ok && s.w_ok && !s.bvalid;
  assign wr_maddr = {s.update[3:2], s.w_data[3:0]};

  // Next state
  always_comb begin
    n = s;
    mif.a_en = 1'b0;
    mif.a_we = 1'b0;
    mif.a_addr = wr_maddr;
    mif.a_wdata = s.data;
    // Pointer read lands in the data register two cycles after it is issued
    case (s.fetch)
      FS_LOAD: begin
        n.data = mif.a_rdata;
        n.fetch = FS_IDLE;
      end
      default: n.fetch = FS_IDLE;
    endcase
    // Write channels are taken in either order
    if (awvalid && awready) begin
      n.aw_ok = 1'b1;
      n.aw_idx = awaddr[11:2];
    end
    if (wvalid && wready) begin
      n.w_ok = 1'b1;
      n.w_data = wdata[7:0];
      n.w_lane = wstrb[0];
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    // Register write once both halves are held
    if (wr_fire) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bslv = !lbs_known(s.aw_idx);
      if (s.w_lane) begin
        case (s.aw_idx)
          `LBS_IDX_MAIN: n.main_cfg = s.w_data;
          `LBS_IDX_SEG_A: n.seg_a = s.w_data;
          `LBS_IDX_SUPPLY: n.supply = s.w_data;
          `LBS_IDX_DATA: n.data = s.w_data;
          `LBS_IDX_UPDATE: n.update = s.w_data;
          `LBS_IDX_SEG_B: n.seg_b = s.w_data;
          `LBS_IDX_PERIPHERAL_CONFIG: n.peripheral_config = s.w_data;
          `LBS_IDX_PTR: begin
            n.ptr = s.w_data;
            if (s.w_data[3:0] != 4'hf) begin
              mif.a_en = 1'b1;
              mif.a_we = s.w_data[`LBS_PTR_WRITE];
              n.fetch = s.w_data[`LBS_PTR_WRITE] ? FS_IDLE : FS_LOAD;
            end
          end
          default: n.main_cfg = s.main_cfg;
        endcase
      end
    end
    // Read channel
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      n.rvalid = 1'b1;
      n.rdata = lbs_read(s, araddr[11:2]);
      n.rslv = !lbs_known(araddr[11:2]);
    end
    // Display on outside sleep by its own bit, in sleep only with sleep disable clear
    n.active = s.main_cfg[`LBS_MAIN_ON] &&
      !(deep_sleep_state && s.main_cfg[`LBS_MAIN_SLEEP_DIS]);
    // Ladder supplies the rails, else the pump runs only while displaying
    n.ladder = s.supply[`LBS_SUP_LADDER];
    n.pump = !n.ladder && n.active;
    // Contrast applies to pump rails only, stored value untouched
    n.level = n.ladder ? 6'h00 : s.supply[5:0];
    // Fixed segments, enabled segments, shared pins lost in four-way mode
    n.seg = {s.seg_b[4:0], s.seg_a, {`LBS_SEG_FIXED{1'b1}}};
    if (lbs_mux_t'(s.main_cfg[1:0]) == MUX_4X) begin
      n.seg[28:27] = 2'b00;
    end
    n.com = lbs_coms(lbs_mux_t'(s.main_cfg[1:0]));
  end

  // Scanner port stalls while frozen so the shown content holds
  always_comb begin
    mif.b_en = !s.update[`LBS_UPD_FREEZE];
    mif.b_addr = {s.update[3:2], view_addr};
  end

  ////////////////////////////////////////////////////////////////
  // State register; display off never clears configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.main_cfg <= `LBS_CFG_RST;
      s.seg_a <= `LBS_CFG_RST;
      s.supply <= `LBS_CFG_RST;
      s.seg_b <= `LBS_CFG_RST;
      s.update <= `LBS_CFG_RST;
      s.ptr <= `LBS_CFG_RST;
      s.data <= `LBS_CFG_RST;
      s.peripheral_config <= `LBS_CFG_RST;
      s.seg <= {{13{1'b0}}, {`LBS_SEG_FIXED{1'b1}}};
      s.com <= 4'h1;
    end else begin
      s <= n;
    end
  end

  // Display memory
  lbs_mem #(.AW(6)) u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .m(mif.mem)
  );

  ////////////////////////////////////////////////////////////////
  // Outputs
  assign bvalid = s.bvalid;
  assign bresp = s.bslv ? `LBS_RESP_SLVERR : `LBS_RESP_OKAY;
  assign rvalid = s.rvalid;
  assign rdata = {24'h000000, s.rdata};
  assign rresp = s.rslv ? `LBS_RESP_SLVERR : `LBS_RESP_OKAY;
  assign view_data = mif.b_rdata;
  assign pump_enable = s.pump;
  assign ladder_source_select = s.ladder;
  assign contrast_level = s.level;
  assign display_active = s.active;
  assign segment_enable = s.seg;
  assign common_enable = s.com;
  assign reference_keepalive = s.peripheral_config[`LBS_PER_REF];

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_pump_off;
    (!s.main_cfg[`LBS_MAIN_ON] || s.supply[`LBS_SUP_LADDER]) |=> !pump_enable;
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump runs with display off or ladder");

  property p_level;
    pump_enable |-> contrast_level == s.supply[5:0] || $past(wr_fire);
  endproperty
  a_level: assert property (p_level) else $error("contrast differs from stored level");

  property p_src_write;
    (wr_fire && s.w_lane && s.aw_idx == `LBS_IDX_SUPPLY) ##2 1 |->
      ladder_source_select == $past(s.w_data[`LBS_SUP_LADDER], 2);
  endproperty
  a_src_write: assert property (p_src_write) else $error("source select not taken");

  property p_ladder_level;
    ladder_source_select |-> contrast_level == 6'h00 && !pump_enable;
  endproperty
  a_ladder_level: assert property (p_ladder_level) else $error("ladder with contrast or pump");

  property p_sleep;
    (deep_sleep_state && s.main_cfg[`LBS_MAIN_SLEEP_DIS]) |=> !display_active;
  endproperty
  a_sleep: assert property (p_sleep) else $error("display on in sleep with sleep disable");

  property p_sleep_on;
    (deep_sleep_state && !s.main_cfg[`LBS_MAIN_SLEEP_DIS] && s.main_cfg[`LBS_MAIN_ON]) |=> display_active;
  endproperty
  a_sleep_on: assert property (p_sleep_on) else $error("display off in sleep when enabled");

  property p_keep;
    (!display_active && !wr_fire) |=> $stable(s.supply) && $stable(s.seg_a) && $stable(s.main_cfg);
  endproperty
  a_keep: assert property (p_keep) else $error("configuration lost while off");

  property p_fixed;
    segment_enable[15:0] == 16'hffff;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed segment disabled");

  property p_mux4;
    (lbs_mux_t'(s.main_cfg[1:0]) == MUX_4X) |=> common_enable == 4'hf && segment_enable[28:27] == 2'b00;
  endproperty
  a_mux4: assert property (p_mux4) else $error("shared pins wrong in four-way mode");

  property p_store;
    (wr_fire && s.w_lane && s.aw_idx == `LBS_IDX_PTR && s.w_data[`LBS_PTR_WRITE] && s.w_data[3:0] != 4'hf)
      |-> mif.a_en && mif.a_we && mif.a_wdata == s.data;
  endproperty
  a_store: assert property (p_store) else $error("pointer write did not store");

  property p_load;
    (wr_fire && s.w_lane && s.aw_idx == `LBS_IDX_PTR && !s.w_data[`LBS_PTR_WRITE] && s.w_data[3:0] != 4'hf)
      |=> ##1 s.data == $past(mif.a_rdata);
  endproperty
  a_load: assert property (p_load) else $error("pointer read did not load");

  property p_freeze;
    (s.update[`LBS_UPD_FREEZE] && $past(s.update[`LBS_UPD_FREEZE])) |-> $stable(view_data);
  endproperty
  a_freeze: assert property (p_freeze) else $error("shown data changed while frozen");

  property p_pump_on;
    (s.main_cfg[`LBS_MAIN_ON] && !deep_sleep_state && !s.supply[`LBS_SUP_LADDER]) |=> pump_enable;
  endproperty
  a_pump_on: assert property (p_pump_on) else $error("pump idle while display shown");

  property p_awake;
    !deep_sleep_state |=> display_active == $past(s.main_cfg[`LBS_MAIN_ON]);
  endproperty
  a_awake: assert property (p_awake) else $error("display state wrong while awake");

  property p_level_back;
    !s.supply[`LBS_SUP_LADDER] |=> contrast_level == $past(s.supply[5:0]);
  endproperty
  a_level_back: assert property (p_level_back) else $error("stored contrast not applied on pump");

  property p_seg_opt;
    (lbs_mux_t'(s.main_cfg[1:0]) != MUX_4X) |=> segment_enable[28:16] == $past({s.seg_b[4:0], s.seg_a});
  endproperty
  a_seg_opt: assert property (p_seg_opt) else $error("optional segment enable wrong");

  // Read answers come one cycle after the address is taken, write answers one cycle after the write fires; both hold until taken
  property p_write_answer;
    wr_fire |=> bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write without response");

  property p_read_answer;
    (arvalid && arready) |=> rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read without response");

  property p_b_hold;
    (bvalid && !bready) |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped before taken");

  property p_r_hold;
    (rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped before taken");

  property p_unmapped;
    (wr_fire && !lbs_known(s.aw_idx)) |=> bresp == `LBS_RESP_SLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write not refused");

  c_write: cover property (wr_fire ##1 bvalid && bready);
  c_sleep_on: cover property (deep_sleep_state && display_active && pump_enable);
  c_ladder_back: cover property (ladder_source_select ##[1:20] pump_enable);
  c_freeze: cover property (s.update[`LBS_UPD_FREEZE] ##[1:20] !s.update[`LBS_UPD_FREEZE]);
  c_load: cover property (s.fetch == FS_LOAD);
endmodule

// File: hw/lbs_defines.svh
// Offsets, field positions, reset values and response codes of the display supply block
// Function
// - With the charge pump chosen and the display off, all display voltage generation is switched off.
// - The supply register holds a six-bit contrast level in bits 5..0, giving 64 levels for the pump voltages.
// - Bit 6 of the supply register picks the source, zero (pump) after reset, one for the external ladder.
// - With the ladder chosen, waveform voltages come from the ladder and no contrast level is applied.
// - In deep sleep the display is steered by bit 4 (sleep disable) and bit 7 (display on) of the main register.
// - In deep sleep the display is on only for sleep disable 0 and display on 1, off otherwise.
// - Configuration and display memory keep their contents while the display is off.
// - Segment lines 0 to 15 are always segments, the others are enabled by the two segment enable registers.
// - In four-way multiplexing all four commons are driven and the two shared pins are not segments.
// - A pointer write with low four bits below 15 and top bit set stores the data register, with top bit clear loads the data register.
// - While the freeze bit is set the shown content stays unchanged until it is cleared.
`ifndef LBS_DEFINES_SVH
`define LBS_DEFINES_SVH
`define LBS_IDX_MAIN 10'h095
`define LBS_IDX_SEG_A 10'h097
`define LBS_IDX_SUPPLY 10'h09c
`define LBS_IDX_PTR 10'h0ac
`define LBS_IDX_DATA 10'h0ae
`define LBS_IDX_UPDATE 10'h0b1
`define LBS_IDX_SEG_B 10'h0ed
`define LBS_IDX_PERIPHERAL_CONFIG 10'h0f4
`define LBS_CFG_RST 8'h00
`define LBS_MAIN_ON 7
`define LBS_MAIN_SLEEP_DIS 4
`define LBS_SUP_LADDER 6
`define LBS_UPD_FREEZE 0
`define LBS_PER_REF 3
`define LBS_PTR_WRITE 7
`define LBS_SEG_FIXED 16
`define LBS_RESP_OKAY 2'h0
`define LBS_RESP_SLVERR 2'h2
`endif

// File: hw/lbs_pkg.sv
// Types of the display supply block
package lbs_pkg;
  typedef enum logic [0:0] {FS_IDLE = 1'b0, FS_LOAD = 1'b1} lbs_fetch_t;
  typedef enum logic [1:0] {MUX_STATIC = 2'b00, MUX_2X = 2'b01, MUX_3X = 2'b10, MUX_4X = 2'b11} lbs_mux_t;
  typedef logic [28:0] lbs_seg_t;
  typedef struct packed {
    logic aw_ok;
    logic [9:0] aw_idx;
    logic w_ok;
    logic [7:0] w_data;
    logic w_lane;
    logic bvalid;
    logic bslv;
    logic rvalid;
    logic rslv;
    logic [7:0] rdata;
    lbs_fetch_t fetch;
    logic [7:0] main_cfg;
    logic [7:0] seg_a;
    logic [7:0] supply;
    logic [7:0] seg_b;
    logic [7:0] update;
    logic [7:0] ptr;
    logic [7:0] data;
    logic [7:0] peripheral_config;
    logic pump;
    logic ladder;
    logic active;
    logic [5:0] level;
    lbs_seg_t seg;
    logic [3:0] com;
  } lbs_state_t;
endpackage

// File: hw/lbs_mem_if.sv
// Carrier between the control logic and the display memory
interface lbs_mem_if #(parameter int AW = 6);
  logic a_en;
  logic a_we;
  logic [AW-1:0] a_addr;
  logic [7:0] a_wdata;
  logic [7:0] a_rdata;
  logic b_en;
  logic [AW-1:0] b_addr;
  logic [7:0] b_rdata;
  modport ctl (output a_en, a_we, a_addr, a_wdata, b_en, b_addr, input a_rdata, b_rdata);
  modport mem (input a_en, a_we, a_addr, a_wdata, b_en, b_addr, output a_rdata, b_rdata);
endinterface

// File: hw/lbs_mem.sv
// Display memory, firmware port and scanner port, registered reads
module lbs_mem #(
  parameter int AW = 6
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Memory ports
  lbs_mem_if.mem m
);
  typedef struct packed {
    logic [7:0] ra;
    logic [7:0] rb;
  } lbs_mst_t;
  logic [7:0] cells [0:(1<<AW)-1];
  lbs_mst_t q;
  lbs_mst_t q_next;

  ////////////////////////////////////////////////////////////////
  // Storage, never cleared so contents survive display off
  always_ff @(posedge aclk) begin
    if (m.a_en && m.a_we) begin
      cells[m.a_addr] <= m.a_wdata;
    end
  end

  // Read registers, port b holds while disabled
  always_comb begin
    q_next = q;
    if (m.a_en) begin
      q_next.ra = cells[m.a_addr];
    end
    if (m.b_en) begin
      q_next.rb = cells[m.b_addr];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= q_next;
    end
  end

  assign m.a_rdata = q.ra;
  assign m.b_rdata = q.rb;
endmodule

// File: verification/lbs_scan_model.sv
// Scanner stand-in that fetches display memory bytes the way the glass driver does
module lbs_scan_model (
  // Clock
  input wire logic aclk,
  // Byte to fetch and the byte seen
  input wire logic [3:0] pick,
  output logic [3:0] view_addr,
  input wire logic [7:0] view_data,
  output logic [7:0] seen
);
  timeunit 1ns;
  timeprecision 100ps;
  // Present the address, then capture the byte after the read latency
  always_ff @(posedge aclk) begin
    view_addr <= pick;
    seen <= view_data;
  end
endmodule

// File: verification/tb_top.sv
// Self-checking bench of the display supply block over AXI4-Lite
`include "lbs_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import lbs_pkg::*;
  localparam logic [1:0] OK = `LBS_RESP_OKAY;
  localparam logic [9:0] REGS [8] = '{`LBS_IDX_MAIN, `LBS_IDX_SEG_A, `LBS_IDX_SUPPLY, `LBS_IDX_PTR,
    `LBS_IDX_DATA, `LBS_IDX_UPDATE, `LBS_IDX_SEG_B, `LBS_IDX_PERIPHERAL_CONFIG};
  localparam logic [3:0] COMS [4] = '{4'h1, 4'h3, 4'h7, 4'hf};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic deep_sleep_state = 1'b0;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic [3:0] wstrb = 4'h1;
  logic [3:0] pick = 4'h0;
  logic [2:0] prot = 3'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic pump_enable, ladder_source_select, display_active, reference_keepalive;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] view_addr, common_enable;
  logic [7:0] view_data, seen;
  logic [5:0] contrast_level;
  lbs_seg_t segment_enable;
  int miscompares = 0;
  int checks_done = 0;
  //////////////////////////////////////////////////////////////////////////////
  // Clock, design and scanner
  always #12.5 aclk = ~aclk;
  lbs_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(prot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(prot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .deep_sleep_state(deep_sleep_state),
    .view_addr(view_addr), .view_data(view_data), .pump_enable(pump_enable),
    .ladder_source_select(ladder_source_select), .contrast_level(contrast_level),
    .display_active(display_active), .segment_enable(segment_enable), .common_enable(common_enable),
    .reference_keepalive(reference_keepalive));
  lbs_scan_model scan (.aclk(aclk), .pick(pick), .view_addr(view_addr), .view_data(view_data), .seen(seen));
  //////////////////////////////////////////////////////////////////////////////
  // Verdict and shared tasks
  task automatic conclude();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tmo();
    miscompares++;
    conclude();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Write one register word; handshakes sampled at the falling edge, acted on at the rising one
  task automatic wr(input logic [9:0] ix, input logic [7:0] d, input logic [1:0] er = OK);
    logic a_hs, w_hs, b_hs;
    int n;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= {20'h0, ix, 2'b00};
    wvalid <= 1'b1;
    wdata <= {24'h0, d};
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      a_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      if (b_hs) chk(bresp, er);
      @(posedge aclk);
      if (a_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) tmo();
  endtask
  // Read one register word and compare data and response
  task automatic rd(input logic [9:0] ix, input logic [7:0] ed, input logic [1:0] er = OK);
    logic a_hs, r_hs;
    int n;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= {20'h0, ix, 2'b00};
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      a_hs = arvalid && arready;
      r_hs = rvalid;
      if (r_hs) chk(rdata, {24'h0, ed});
      if (r_hs) chk(rresp, er);
      @(posedge aclk);
      if (a_hs) arvalid <= 1'b0;
      if (r_hs) begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) tmo();
  endtask
  // Let registered outputs land before looking at them
  task automatic st();
    repeat (3) @(negedge aclk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    tmo();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    st();
    chk(32'(segment_enable), 32'h0000ffff);
    chk(common_enable, 4'h1);
    chk(pump_enable, 1'b0);
    for (int i = 0; i < 8; i++) rd(REGS[i], 8'h00);
    // Sleep table with the display enable and sleep disable bits
    deep_sleep_state <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(`LBS_IDX_MAIN, {i[1], 2'b00, i[0], 4'h0});
      st();
      chk(display_active, i[1] & ~i[0]);
      chk(pump_enable, i[1] & ~i[0]);
    end
    wr(`LBS_IDX_MAIN, 8'h90);
    deep_sleep_state <= 1'b0;
    st();
    chk(display_active, 1'b1);
    // Pump source, ladder source and back
    wr(`LBS_IDX_SUPPLY, 8'h2e);
    st();
    chk(contrast_level, 6'h2e);
    chk(pump_enable, 1'b1);
    wr(`LBS_IDX_SUPPLY, 8'h6e);
    st();
    chk(ladder_source_select, 1'b1);
    chk(contrast_level, 6'h00);
    chk(pump_enable, 1'b0);
    rd(`LBS_IDX_SUPPLY, 8'h6e);
    wr(`LBS_IDX_SUPPLY, 8'h2e);
    st();
    chk(contrast_level, 6'h2e);
    wr(`LBS_IDX_MAIN, 8'h10);
    st();
    chk(pump_enable, 1'b0);
    // Multiplexing modes with every optional segment enabled, then part of them in four-way mode
    wr(`LBS_IDX_SEG_A, 8'hff);
    wr(`LBS_IDX_SEG_B, 8'h1f);
    for (int m = 0; m < 4; m++) begin
      wr(`LBS_IDX_MAIN, 8'(m));
      st();
      chk(common_enable, COMS[m]);
      chk(32'(segment_enable), (m == 3) ? 32'h07ffffff : 32'h1fffffff);
    end
    wr(`LBS_IDX_SEG_A, 8'h0f);
    wr(`LBS_IDX_SEG_B, 8'h01);
    st();
    chk(32'(segment_enable), 32'h010fffff);
    // Reference keepalive and unmapped places
    wr(`LBS_IDX_PERIPHERAL_CONFIG, 8'h08);
    st();
    chk(reference_keepalive, 1'b1);
    wr(10'h000, 8'hff, `LBS_RESP_SLVERR);
    rd(10'h000, 8'h00, `LBS_RESP_SLVERR);
    // A write with the low byte lane off leaves the register alone
    wstrb <= 4'h0;
    wr(`LBS_IDX_SUPPLY, 8'hff);
    wstrb <= 4'h1;
    rd(`LBS_IDX_SUPPLY, 8'h2e);
    // Display memory store, frozen update and release
    pick <= 4'h5;
    wr(`LBS_IDX_DATA, 8'h11);
    wr(`LBS_IDX_PTR, 8'h85);
    st();
    chk(seen, 8'h11);
    wr(`LBS_IDX_UPDATE, 8'h01);
    wr(`LBS_IDX_DATA, 8'h5a);
    wr(`LBS_IDX_PTR, 8'h85);
    st();
    chk(seen, 8'h11);
    wr(`LBS_IDX_UPDATE, 8'h00);
    st();
    chk(seen, 8'h5a);
    // Second screen shown and written, first screen untouched
    wr(`LBS_IDX_UPDATE, 8'h04);
    wr(`LBS_IDX_DATA, 8'h77);
    wr(`LBS_IDX_PTR, 8'h85);
    st();
    chk(seen, 8'h77);
    wr(`LBS_IDX_UPDATE, 8'h00);
    st();
    chk(seen, 8'h5a);
    wr(`LBS_IDX_MAIN, 8'h00);
    wr(`LBS_IDX_DATA, 8'h00);
    wr(`LBS_IDX_PTR, 8'h05);
    st();
    rd(`LBS_IDX_DATA, 8'h5a);
    rd(`LBS_IDX_SUPPLY, 8'h2e);
    chk(seen, 8'h5a);
    conclude();
  end
endmodule
